//--- include/hrr_defs.svh
// Purpose: Constants for the hard row repair sequencer
// Assumes: 20 MHz core clock
// Notes: Times are kept in their own units; cycle counts derive from them
`ifndef HRR_DEFS_SVH
`define HRR_DEFS_SVH

`define HRR_CLK_MHZ 20
// Mode register four enable bit position
`define HRR_MR4_BIT 13
// Mode register selects on {bg, ba}
`define HRR_SEL_MR0 4'h0
`define HRR_SEL_MR4 4'h4
// Guard key address bits 11..7, bits 6..0 must read all ones
`define HRR_KEY0 5'h19
`define HRR_KEY1 5'h0F
`define HRR_KEY2 5'h17
`define HRR_KEY3 5'h07
`define HRR_KEY_LOW 7'h7F
// Data burst: four clocks, eight beats
`define HRR_BURST_CLKS 3'h4
`define HRR_HIGH_MIN_CLKS 3'h2
// Timing figures
`define HRR_PGM_TIME_X8_MS 1000
`define HRR_PGM_TIME_X16_MS 2000
`define HRR_PGM_EXIT_NS 15
`define HRR_EXIT_US 50
`define HRR_PGM_CYC(ms) ((ms) * 1000 * `HRR_CLK_MHZ)
`define HRR_PGM_EXIT_CYC \
  (((`HRR_PGM_EXIT_NS * `HRR_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
   ((`HRR_PGM_EXIT_NS * `HRR_CLK_MHZ + 999) / 1000))
`define HRR_EXIT_CYC (`HRR_EXIT_US * `HRR_CLK_MHZ)

`endif

//--- include/hrr_pkg.sv
// Purpose: Types shared by the repair sequencer modules
// Assumes: Commands arrive already decoded
// Notes: None
package hrr_pkg;

  typedef enum logic [2:0] {
    HRR_CMD_DES,
    HRR_CMD_MRS,
    HRR_CMD_ACT,
    HRR_CMD_WR,
    HRR_CMD_WRA,
    HRR_CMD_PRE,
    HRR_CMD_REF,
    HRR_CMD_OTHER
  } hrr_cmd_e;

  typedef enum logic [1:0] {
    HRR_RES_LOW,
    HRR_RES_HIGH,
    HRR_RES_UNDEF
  } hrr_result_e;

endpackage : hrr_pkg

//--- include/hrr_burst_if.sv
// Purpose: Link between the sequencer and its burst checker
// Assumes: One clock domain
// Notes: start marks the cycle the repair write is taken
`timescale 1ns/1ps
`default_nettype none
interface hrr_burst_if
  import hrr_pkg::*;
#(
  parameter int DQ_W = 8
);
  logic start;
  logic [5:0] wl;
  logic [2*DQ_W-1:0] dq;
  logic done;
  hrr_result_e result;

  modport seq (output start, output wl, output dq, input done,
    input result);
  modport chk (input start, input wl, input dq, output done,
    output result);
endinterface : hrr_burst_if
`default_nettype wire

//--- rtl/hrr_burst_check.sv
// Purpose: Judge the four-clock data burst of the repair write
// Assumes: Two beats per clock, even beat in the low half of dq
// Notes: Latency below one clock is treated as one
`timescale 1ns/1ps
`default_nettype none
`include "hrr_defs.svh"
module hrr_burst_check
  import hrr_pkg::*;
#(
  parameter int DQ_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sequencer side
  hrr_burst_if.chk bus
);

  typedef struct packed {
    logic wait_wl;
    logic beats;
    logic [5:0] cnt;
    logic [2:0] beat;
    logic any_high;
    logic [2:0] run_high;
    logic [2:0] max_high;
    logic done;
    hrr_result_e result;
  } hrr_chk_s;

  hrr_chk_s s;
  hrr_chk_s next_s;
  logic all_low;
  logic all_high;
  logic [2:0] run;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    all_low = ~|bus.dq;
    all_high = &bus.dq;
    run = all_high ? s.run_high + 3'h1 : 3'h0;
    if (bus.start) begin
      // First beat stands at the edge that is WL clocks after the write
      next_s.wait_wl = (bus.wl > 6'h01);
      next_s.beats = (bus.wl <= 6'h01);
      next_s.cnt = (bus.wl > 6'h01) ? bus.wl - 6'h01 : 6'h00;
      next_s.any_high = 1'b0;
      next_s.run_high = 3'h0;
      next_s.max_high = 3'h0;
      next_s.beat = 3'h0;
    end else if (s.wait_wl) begin
      next_s.cnt = s.cnt - 6'h01;
      if (s.cnt == 6'h01) begin
        next_s.wait_wl = 1'b0;
        next_s.beats = 1'b1;
      end
    end
    // Samples are taken while the beats window is open
    if (s.beats && !bus.start) begin
      next_s.any_high = s.any_high | ~all_low;
      next_s.run_high = run;
      if (run > s.max_high) begin
        next_s.max_high = run;
      end
      next_s.beat = s.beat + 3'h1;
      if (s.beat == `HRR_BURST_CLKS - 3'h1) begin
        next_s.beats = 1'b0;
        next_s.done = 1'b1;
        if (!(s.any_high | ~all_low)) begin
          next_s.result = HRR_RES_LOW;
        end else if (((run > s.max_high) ? run : s.max_high) >=
                     `HRR_HIGH_MIN_CLKS) begin
          next_s.result = HRR_RES_HIGH;
        end else begin
          next_s.result = HRR_RES_UNDEF;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.done = s.done;
  assign bus.result = s.result;

endmodule : hrr_burst_check
`default_nettype wire

//--- rtl/hrr_top.sv
// Purpose: Device-side hard row repair sequencer, write-initiated variant
// Assumes: Commands decoded and inputs synchronous to clock
// Notes: Refresh is forbidden while the mode is active
// Contract
// - Mode register four bit enables, DQ high
// - Four ordered guard keys, no interruption
// - Repair starts only if all low
// - Any high bit blocks the repair
// - Two high clocks skip, keep data
// - Other patterns give an undefined outcome
`timescale 1ns/1ps
`default_nettype none
`include "hrr_defs.svh"
module hrr_top
  import hrr_pkg::*;
#(
  parameter int DQ_W = 8,
  parameter int PGM_CYCLES = (DQ_W == 16) ?
    `HRR_PGM_CYC(`HRR_PGM_TIME_X16_MS) : `HRR_PGM_CYC(`HRR_PGM_TIME_X8_MS),
  parameter int EXIT_CYCLES = `HRR_EXIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Decoded command and address
  input wire hrr_cmd_e cmd,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic banks_idle,
  input wire logic [5:0] write_latency,
  // Data pins, two beats per clock
  input wire logic [2*DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  // Status towards the array
  output logic hard_row_repair_mode,
  output logic keys_rejected,
  output logic repair_start,
  output logic repair_busy,
  output logic repair_ok,
  output logic repair_skipped,
  output logic repair_undefined,
  output logic ref_violation,
  output logic mode_exiting,
  output logic [1:0] fail_bg,
  output logic [1:0] fail_ba,
  output logic [17:0] fail_row
);

  localparam int CW = $clog2(PGM_CYCLES + EXIT_CYCLES + 2);
  localparam logic [CW-1:0] PGM_C = CW'(PGM_CYCLES);
  localparam logic [CW-1:0] PEX_C = CW'(`HRR_PGM_EXIT_CYC);
  localparam logic [CW-1:0] EXIT_C = CW'(EXIT_CYCLES);

  typedef enum logic [3:0] {
    ST_NORMAL, ST_KEYS, ST_LOCKED, ST_ARMED, ST_ROW, ST_BURST,
    ST_PROGRAM, ST_HOLD, ST_RECOG, ST_DONE, ST_EXIT
  } hrr_state_e;

  typedef struct packed {
    hrr_state_e st;
    logic [1:0] key_idx;
    logic [CW-1:0] cnt;
    logic pre_seen;
    logic dq_high;
    logic oe;
    logic mode;
    logic keys_rej;
    logic start;
    logic busy;
    logic ok;
    logic skipped;
    logic undef;
    logic ref_bad;
    logic exiting;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] row;
  } hrr_top_s;

  hrr_top_s s;
  hrr_top_s next_s;

  hrr_burst_if #(.DQ_W(DQ_W)) bif ();

  hrr_burst_check #(.DQ_W(DQ_W)) u_chk (
    .clock(clock),
    .rst(rst),
    .bus(bif.chk)
  );

  function automatic logic key_match(input logic [1:0] idx,
                                     input logic [1:0] kbg,
                                     input logic [1:0] kba,
                                     input logic [17:0] a);
    logic [4:0] want;
    case (idx)
      2'h0: want = `HRR_KEY0;
      2'h1: want = `HRR_KEY1;
      2'h2: want = `HRR_KEY2;
      default: want = `HRR_KEY3;
    endcase
    return ({kbg, kba} == `HRR_SEL_MR0) && (a[11:7] == want) &&
           (a[6:0] == `HRR_KEY_LOW);
  endfunction : key_match

  function automatic logic is_mr4(input hrr_cmd_e c,
                                  input logic [1:0] mbg,
                                  input logic [1:0] mba);
    return (c == HRR_CMD_MRS) && ({mbg, mba} == `HRR_SEL_MR4);
  endfunction : is_mr4

  logic wr_hit;

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    // Only a plain write to the captured bank starts the data check
    wr_hit = (s.st == ST_ROW) && (cmd == HRR_CMD_WR) &&
             (bg == s.bg) && (ba == s.ba);
    if (s.mode && cmd == HRR_CMD_REF) begin
      next_s.ref_bad = 1'b1;
    end
    if (s.st != ST_PROGRAM && s.cnt != '0) begin
      next_s.cnt = s.cnt - CW'(1);
    end
    case (s.st)
      ST_NORMAL: begin
        if (is_mr4(cmd, bg, ba) && addr[`HRR_MR4_BIT] && banks_idle) begin
          next_s.st = ST_KEYS;
          next_s.mode = 1'b1;
          next_s.dq_high = 1'b1;
          next_s.oe = 1'b1;
          next_s.key_idx = 2'h0;
          next_s.keys_rej = 1'b0;
          next_s.ok = 1'b0;
          next_s.skipped = 1'b0;
          next_s.undef = 1'b0;
          next_s.ref_bad = 1'b0;
        end
      end
      ST_KEYS: begin
        if (cmd != HRR_CMD_DES) begin
          if (cmd == HRR_CMD_MRS && key_match(s.key_idx, bg, ba, addr)) begin
            next_s.key_idx = s.key_idx + 2'h1;
            if (s.key_idx == 2'h3) begin
              next_s.st = ST_ARMED;
            end
          end else begin
            // A broken key sequence leaves later commands as normal ones
            next_s.st = ST_LOCKED;
            next_s.keys_rej = 1'b1;
          end
        end
      end
      ST_ARMED: begin
        if (cmd == HRR_CMD_ACT) begin
          next_s.st = ST_ROW;
          next_s.bg = bg;
          next_s.ba = ba;
          next_s.row = addr;
        end
      end
      ST_ROW: begin
        if (wr_hit) begin
          // Release DQ so the controller can drive the burst
          next_s.st = ST_BURST;
          next_s.oe = 1'b0;
        end
      end
      ST_BURST: begin
        if (bif.done) begin
          next_s.oe = 1'b1;
          if (bif.result == HRR_RES_LOW) begin
            next_s.st = ST_PROGRAM;
            next_s.start = 1'b1;
            next_s.busy = 1'b1;
            next_s.cnt = PGM_C;
            next_s.pre_seen = 1'b0;
          end else begin
            next_s.st = ST_HOLD;
            next_s.skipped = (bif.result == HRR_RES_HIGH);
            next_s.undef = (bif.result == HRR_RES_UNDEF);
          end
        end
      end
      ST_PROGRAM: begin
        // An early precharge cannot cut the fuse time short
        if (cmd == HRR_CMD_PRE) begin
          next_s.pre_seen = 1'b1;
        end
        if (s.cnt > CW'(1)) begin
          next_s.cnt = s.cnt - CW'(1);
        end else begin
          next_s.busy = 1'b0;
          next_s.ok = 1'b1;
          next_s.cnt = '0;
          next_s.st = ST_HOLD;
          if (s.pre_seen || cmd == HRR_CMD_PRE) begin
            next_s.st = ST_RECOG;
            next_s.cnt = PEX_C;
          end
        end
      end
      ST_HOLD: begin
        if (cmd == HRR_CMD_PRE) begin
          next_s.st = ST_RECOG;
          next_s.cnt = PEX_C;
        end
      end
      ST_RECOG: begin
        if (s.cnt <= CW'(1)) begin
          next_s.st = ST_DONE;
        end
      end
      ST_EXIT: begin
        if (s.cnt <= CW'(1)) begin
          next_s.st = ST_NORMAL;
          next_s.exiting = 1'b0;
        end
      end
      default: begin
      end
    endcase
    // Clearing the enable bit leaves the mode from any repair state except ST_PROGRAM
    if (s.mode && is_mr4(cmd, bg, ba) && !addr[`HRR_MR4_BIT] &&
        s.st != ST_PROGRAM) begin
      next_s.st = ST_EXIT;
      next_s.mode = 1'b0;
      next_s.dq_high = 1'b0;
      next_s.oe = 1'b0;
      next_s.exiting = 1'b1;
      next_s.cnt = EXIT_C;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bif.start = wr_hit;
  assign bif.wl = write_latency;
  assign bif.dq = dq_in;

  assign dq_out = {DQ_W{s.dq_high}};
  assign dq_oe = s.oe;
  assign hard_row_repair_mode = s.mode;
  assign keys_rejected = s.keys_rej;
  assign repair_start = s.start;
  assign repair_busy = s.busy;
  assign repair_ok = s.ok;
  assign repair_skipped = s.skipped;
  assign repair_undefined = s.undef;
  assign ref_violation = s.ref_bad;
  assign mode_exiting = s.exiting;
  assign fail_bg = s.bg;
  assign fail_ba = s.ba;
  assign fail_row = s.row;

endmodule : hrr_top
`default_nettype wire

//--- testbench/hrr_top_chk.sv
// Purpose: Port-level checks of the repair sequencer
// Assumes: One clock domain, rst async active high
// Notes: Run lengths allow one cycle of slack either way
`timescale 1ns/1ps
`default_nettype none
module hrr_top_chk
  import hrr_pkg::*;
#(
  parameter int DQ_W = 8,
  parameter int PGM_CYCLES = 20,
  parameter int EXIT_CYCLES = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Command side
  input wire hrr_cmd_e cmd,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic banks_idle,
  // Device side
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic hard_row_repair_mode,
  input wire logic keys_rejected,
  input wire logic repair_start,
  input wire logic repair_busy,
  input wire logic repair_ok,
  input wire logic repair_skipped,
  input wire logic repair_undefined,
  input wire logic ref_violation,
  input wire logic mode_exiting,
  input wire logic [17:0] fail_row
);
  int bz;
  int ex;
  logic m4;
  assign m4 = cmd == HRR_CMD_MRS && {bg, ba} == 4'h4 && addr[13];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Counters, since the runs are too long to unroll as repetitions
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bz <= 0;
      ex <= 0;
    end else begin
      bz <= repair_busy ? bz + 1 : 0;
      ex <= mode_exiting ? ex + 1 : 0;
    end
  end
  chk_entry_taken: assert property (
    m4 && banks_idle && !hard_row_repair_mode && !mode_exiting |=>
    hard_row_repair_mode && dq_oe && &dq_out) else $error("entry lost");
  chk_entry_refused: assert property (
    m4 && !banks_idle && !hard_row_repair_mode |=> !hard_row_repair_mode)
    else $error("entry while busy banks");
  chk_start_pulse: assert property (
    repair_start |-> repair_busy && !keys_rejected ##1 !repair_start)
    else $error("bad start pulse");
  chk_pgm_length: assert property (
    $fell(repair_busy) |-> repair_ok &&
    bz inside {[PGM_CYCLES - 1:PGM_CYCLES + 1]}) else $error("pgm length");
  chk_no_repair: assert property (
    repair_skipped || repair_undefined |-> !repair_busy && !repair_ok)
    else $error("repair despite bad burst");
  chk_ref_flag: assert property (
    cmd == HRR_CMD_REF && hard_row_repair_mode |=> ref_violation)
    else $error("refresh not flagged");
  chk_row_capture: assert property (
    $changed(fail_row) |-> $past(cmd) == HRR_CMD_ACT &&
    fail_row == $past(addr)) else $error("row capture");
  chk_exit_wait: assert property (
    $fell(mode_exiting) |-> !hard_row_repair_mode && !dq_oe &&
    ex inside {[EXIT_CYCLES - 1:EXIT_CYCLES + 1]}) else $error("exit wait");
  cov_start: cover property (repair_start);
  cov_skip: cover property ($rose(repair_skipped));
  cov_undef: cover property ($rose(repair_undefined));
  cov_exit: cover property ($fell(mode_exiting));
endmodule : hrr_top_chk
bind hrr_top hrr_top_chk #(.DQ_W(DQ_W), .PGM_CYCLES(PGM_CYCLES),
  .EXIT_CYCLES(EXIT_CYCLES)) hrr_top_chk_i (.clock, .rst, .cmd, .bg, .ba,
  .addr, .banks_idle, .dq_out, .dq_oe, .hard_row_repair_mode,
  .keys_rejected, .repair_start, .repair_busy, .repair_ok, .repair_skipped,
  .repair_undefined, .ref_violation, .mode_exiting, .fail_row);
`default_nettype wire

//--- testbench/hrr_ctrl_model.sv
// Purpose: Memory controller model driving commands and data
// Assumes: x8 part, two beats per clock
// Notes: Idle data lines toggle so stale values never pass for a burst
`timescale 1ns/1ps
`default_nettype none
module hrr_ctrl_model
  import hrr_pkg::*;
(
  // Clock and latency
  input wire logic clock,
  input wire logic [5:0] write_latency,
  // Command and data
  output var hrr_cmd_e cmd,
  output var logic [1:0] bg,
  output var logic [1:0] ba,
  output var logic [17:0] addr,
  output logic [15:0] dq_in
);
  logic [15:0] idle = 16'h5A5A;
  logic [15:0] beat = 16'h0000;
  logic on = 1'b0;
  assign dq_in = on ? beat : idle;
  always @(negedge clock) idle <= ~idle;
  initial begin
    cmd = HRR_CMD_DES;
    {bg, ba, addr} = '0;
  end
  // One command, then a deselect cycle; no refresh of its own
  task automatic issue(input hrr_cmd_e c, input logic [3:0] s,
    input logic [17:0] a);
    @(negedge clock);
    cmd = c;
    {bg, ba} = s;
    addr = a;
    @(negedge clock);
    cmd = HRR_CMD_DES;
  endtask : issue
  task automatic write_burst(input logic [3:0] s, input logic [63:0] p);
    issue(HRR_CMD_WR, s, 18'h00000);
    repeat (write_latency - 6'h01) @(negedge clock);
    // Strobe not modelled; each beat pair stands a full clock
    for (int k = 0; k < 4; k++) begin
      beat = p[16*k +: 16];
      on = 1'b1;
      @(negedge clock);
    end
    on = 1'b0;
  endtask : write_burst
endmodule : hrr_ctrl_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the repair sequencer
// Assumes: Short programming and exit counts
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
`include "hrr_defs.svh"
module tb
  import hrr_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic banks_idle = 1'b1;
  logic [5:0] write_latency = 6'h05;
  hrr_cmd_e cmd;
  logic [1:0] bg, ba, fail_bg, fail_ba;
  logic [17:0] addr, fail_row;
  logic [15:0] dq_in;
  logic [7:0] dq_out;
  logic dq_oe, hard_row_repair_mode, keys_rejected, repair_start;
  logic repair_busy, repair_ok, repair_skipped, repair_undefined;
  logic ref_violation, mode_exiting;
  int error_cnt = 0;
  int compares = 0;
  int starts = 0;
  always #25 clock = ~clock;
  // Counted mid-cycle so the pulse is seen once, after it has settled
  always @(negedge clock) if (repair_start === 1'b1) starts++;
  hrr_top #(.PGM_CYCLES(20), .EXIT_CYCLES(5)) hrr_top_i (.clock, .rst, .cmd,
    .bg, .ba, .addr, .banks_idle, .write_latency, .dq_in, .dq_out, .dq_oe,
    .hard_row_repair_mode, .keys_rejected, .repair_start, .repair_busy,
    .repair_ok, .repair_skipped, .repair_undefined, .ref_violation,
    .mode_exiting, .fail_bg, .fail_ba, .fail_row);
  hrr_ctrl_model hrr_ctrl_model_i (.clock, .write_latency, .cmd, .bg, .ba,
    .addr, .dq_in);
  task automatic chk(input string n, input logic [17:0] e,
    input logic [17:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic go(input hrr_cmd_e c, input logic [3:0] s,
    input logic [17:0] a);
    hrr_ctrl_model_i.issue(c, s, a);
  endtask : go
  task automatic arm(input bit bad);
    logic [4:0] k [4] = '{`HRR_KEY0, `HRR_KEY1, `HRR_KEY2, `HRR_KEY3};
    go(HRR_CMD_MRS, 4'h4, 18'h02000);
    chk("mode", 1'b1, hard_row_repair_mode);
    chk("dq_out", 8'hFF, dq_out);
    chk("dq_oe", 1'b1, dq_oe);
    foreach (k[i]) go(HRR_CMD_MRS, 4'h0, {6'h00, k[i ^ bad], 7'h7F});
  endtask : arm
  task automatic fire(input logic [63:0] p);
    go(HRR_CMD_ACT, 4'h9, 18'h2A5A5);
    hrr_ctrl_model_i.write_burst(4'h9, p);
    repeat (4) @(negedge clock);
  endtask : fire
  // Full exit walk, so the next scenario repeats the sequence
  task automatic leave();
    go(HRR_CMD_PRE, 4'h9, 18'h00000);
    repeat (2) @(negedge clock);
    go(HRR_CMD_MRS, 4'h4, 18'h00000);
    chk("mode", 1'b0, hard_row_repair_mode);
    chk("exiting", 1'b1, mode_exiting);
    repeat (6) @(negedge clock);
    chk("exiting", 1'b0, mode_exiting);
    go(HRR_CMD_MRS, 4'h0, 18'h00A30);
  endtask : leave
  task automatic t_idle();
    banks_idle = 1'b0;
    go(HRR_CMD_MRS, 4'h4, 18'h02000);
    chk("mode", 1'b0, hard_row_repair_mode);
    banks_idle = 1'b1;
  endtask : t_idle
  task automatic t_ok();
    int s = starts;
    arm(1'b0);
    fire(64'h0);
    chk("fail_row", 18'h2A5A5, fail_row);
    chk("fail_bank", 4'h9, {fail_bg, fail_ba});
    chk("starts", s + 1, starts);
    chk("busy", 1'b1, repair_busy);
    for (int i = 0; i < 40 && repair_ok !== 1'b1; i++) @(negedge clock);
    chk("ok", 1'b1, repair_ok);
    leave();
    // Checking write to the repaired row must not start another repair
    go(HRR_CMD_ACT, 4'h9, 18'h2A5A5);
    hrr_ctrl_model_i.write_burst(4'h9, 64'h0);
    repeat (4) @(negedge clock);
    chk("starts", s + 1, starts);
  endtask : t_ok
  task automatic t_skip();
    int s = starts;
    write_latency = 6'h01;
    arm(1'b0);
    fire(64'h0000_0000_FFFF_FFFF);
    chk("skipped", 1'b1, repair_skipped);
    chk("starts", s, starts);
    leave();
    write_latency = 6'h05;
  endtask : t_skip
  task automatic t_undef();
    int s = starts;
    arm(1'b0);
    fire(64'h8000_0000_0000_0000);
    chk("undefined", 1'b1, repair_undefined);
    chk("starts", s, starts);
    go(HRR_CMD_REF, 4'h0, 18'h00000);
    chk("ref_flag", 1'b1, ref_violation);
    leave();
  endtask : t_undef
  task automatic t_keys();
    int s = starts;
    arm(1'b1);
    chk("rejected", 1'b1, keys_rejected);
    fire(64'h0);
    chk("starts", s, starts);
    leave();
  endtask : t_keys
  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    t_idle();
    t_ok();
    t_skip();
    t_undef();
    t_keys();
    results();
  end
  // The tests need about 210 cycles; fourteen times that means a hang
  initial begin
    #150000;
    error_cnt++;
    results();
  end
endmodule : tb
`default_nettype wire
